// file: core/gscr_pkg.sv
// constants, register map and field layout of the gas sensor configuration register bank
// How it works
// - baseline correction runs while control bit 1 is zero, stops when one
// - baseline period register holds hours; zero also disables baseline correction
// - dynamic filter active only while control bits 2 and 3 are clear
// - bits 2 and 3 both set: no static and no dynamic filter
// - pressure compensation enabled while control bit 4 is zero
// - control bit 4 set disables pressure compensation of the result
// - compensate with pressure register, but never if it was never written
// - pressure register counts 0.1 hPa steps; host writes ten times hPa
// - pressure outside 3000 to 13000 is clamped to the nearer limit
// - new pressure takes effect at the next gas calculation tick
// - command 0x7c06 starts background calibration; outcome read from status register
// - host writes calibration target first, then command 0x7c05 starts target calibration
// - new bus address stored, used for matching only after reset
// - scaling numerator and denominator in two consecutive registers, revision 4.10 onward
package gscr_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;

   localparam logic [7:0]  REG_CAL_STATUS  = 8'h00;
   localparam logic [7:0]  REG_CAL_CMD     = 8'h01;
   localparam logic [7:0]  REG_CAL_TARGET  = 8'h02;
   localparam logic [7:0]  REG_ABC_PERIOD  = 8'h0d;
   localparam logic [7:0]  REG_METER_CTRL  = 8'h12;
   localparam logic [7:0]  REG_BUS_ADDR    = 8'h13;
   localparam logic [7:0]  REG_SCALE_NUM   = 8'h14;
   localparam logic [7:0]  REG_SCALE_DEN   = 8'h15;
   localparam logic [7:0]  REG_PRESSURE    = 8'h2e;

   localparam int          CTRL_ABC_OFF    = 1;
   localparam int          CTRL_IIR_A      = 2;
   localparam int          CTRL_IIR_B      = 3;
   localparam int          CTRL_PCOMP_OFF  = 4;

   localparam logic [15:0] CMD_CAL_BG      = 16'h7c06;
   localparam logic [15:0] CMD_CAL_TARGET  = 16'h7c05;

   // 0.1 hPa units: 300 hPa and 1300 hPa
   localparam logic signed [15:0] PRESS_MIN = 16'sh0bb8;
   localparam logic signed [15:0] PRESS_MAX = 16'sh32c8;

   localparam logic [15:0] METER_CTRL_RST  = 16'h0000;
   localparam logic [15:0] ABC_PERIOD_RST  = 16'h00b4;
   localparam logic [15:0] CAL_TARGET_RST  = 16'h0000;
   localparam logic [15:0] BUS_ADDR_RST    = 16'h0068;
   localparam logic [15:0] SCALE_NUM_RST   = 16'h0001;
   localparam logic [15:0] SCALE_DEN_RST   = 16'h0001;
   localparam logic [15:0] ZERO16          = 16'h0000;

   localparam logic [15:0] FW_REV          = 16'h040a;
   localparam logic [15:0] FW_SCALE_MIN    = 16'h040a;

   localparam logic [7:0]  FUNC_READ       = 8'h03;
   localparam logic [7:0]  FUNC_WRITE      = 8'h10;
   localparam logic [2:0]  ECHO_BYTES      = 3'h6;
   localparam logic [15:0] CRC_INIT        = 16'hffff;
   localparam logic [15:0] CRC_POLY        = 16'ha001;

   typedef enum logic [2:0] {
      ECHO_IDLE = 3'b001,
      ECHO_CRC  = 3'b010,
      ECHO_DONE = 3'b100
   } gscr_echo_t;
endpackage

// file: core/gscr_crc.sv
// modbus crc-16 accumulator, one byte per cycle
`timescale 1ns/1ns
module gscr_crc (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        init,
   input  wire logic        byte_valid,
   input  wire logic [7:0]  byte_in,
   output logic      [15:0] crc
);
   import gscr_pkg::*;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         if (r[0]) begin
            r = (r >> 1) ^ CRC_POLY;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         crc <= CRC_INIT;
      end else if (init) begin
         crc <= CRC_INIT;
      end else if (byte_valid) begin
         crc <= crc_byte(crc, byte_in);
      end
   end
endmodule

// file: core/gscr_top.sv
// configuration and command register bank of the gas sensor, with request echo builder
`timescale 1ns/1ns
module gscr_top (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  soft_reset,
   input  wire logic [gscr_pkg::ADDR_W-1:0] addr,
   input  wire logic [gscr_pkg::DATA_W-1:0] wdata,
   input  wire logic                  wr,
   input  wire logic                  rd,
   output logic      [gscr_pkg::DATA_W-1:0] rdata,
   input  wire logic [15:0]           cal_status_set,
   input  wire logic                  calc_tick,
   input  wire logic                  echo_req,
   input  wire logic [7:0]            echo_func_in,
   input  wire logic [15:0]           echo_start_in,
   input  wire logic [15:0]           echo_count_in,
   output logic                       echo_valid,
   output logic      [7:0]            echo_slave,
   output logic      [7:0]            echo_func,
   output logic      [15:0]           echo_start,
   output logic      [15:0]           echo_count,
   output logic      [15:0]           echo_crc,
   output logic                       abc_enable,
   output logic      [15:0]           abc_period,
   output logic                       iir_dynamic_en,
   output logic                       iir_static_en,
   output logic                       press_comp_en,
   output logic                       press_applied,
   output logic      [15:0]           press_used,
   output logic                       cal_bg_start,
   output logic                       cal_target_start,
   output logic      [15:0]           cal_target_value,
   output logic      [7:0]            bus_address,
   output logic      [15:0]           scale_num,
   output logic      [15:0]           scale_den
);
   import gscr_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   function automatic logic [15:0] clamp_press(input logic [15:0] v);
      logic signed [15:0] s;
      s = $signed(v);
      if (s < PRESS_MIN) begin
         return PRESS_MIN;
      end else if (s > PRESS_MAX) begin
         return PRESS_MAX;
      end
      return v;
   endfunction

   logic [15:0] meter_ctrl_q;
   logic [15:0] abc_period_q;
   logic [15:0] cal_status_q;
   logic [15:0] cal_target_q;
   logic [15:0] bus_addr_q;
   logic [15:0] scale_num_q;
   logic [15:0] scale_den_q;
   logic [15:0] pressure_q;
   logic        press_written_q;
   logic        addr_load_q;
   logic [15:0] rdata_q;
   logic        wr_pressure;
   logic        wr_scale;

   assign wr_pressure = wr && hit(addr, REG_PRESSURE);
   assign wr_scale    = wr && (FW_REV >= FW_SCALE_MIN);

   // control register: host does read-modify-write
   // whole word stored as written
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meter_ctrl_q <= METER_CTRL_RST;
      end else if (wr && hit(addr, REG_METER_CTRL)) begin
         meter_ctrl_q <= wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         abc_period_q <= ABC_PERIOD_RST;
      end else if (wr && hit(addr, REG_ABC_PERIOD)) begin
         abc_period_q <= wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cal_target_q <= CAL_TARGET_RST;
      end else if (wr && hit(addr, REG_CAL_TARGET)) begin
         cal_target_q <= wdata;
      end
   end

   // status: engine sets bits, host write clears the bits written as zero; set wins
   // outcome readable
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cal_status_q <= ZERO16;
      end else if (wr && hit(addr, REG_CAL_STATUS)) begin
         cal_status_q <= (cal_status_q & wdata) | cal_status_set;
      end else begin
         cal_status_q <= cal_status_q | cal_status_set;
      end
   end

   // calibration command decode, one-cycle starts
   // background calibration start
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cal_bg_start <= 1'b0;
      end else begin
         cal_bg_start <= wr && hit(addr, REG_CAL_CMD) && (wdata == CMD_CAL_BG);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cal_target_start <= 1'b0;
         cal_target_value <= CAL_TARGET_RST;
      end else begin
         cal_target_start <= wr && hit(addr, REG_CAL_CMD) && (wdata == CMD_CAL_TARGET);
         cal_target_value <= cal_target_q;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_addr_q <= BUS_ADDR_RST;
      end else if (wr && hit(addr, REG_BUS_ADDR)) begin
         bus_addr_q <= wdata;
      end
   end

   // load request raised after power-on release and by the reset command
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addr_load_q <= 1'b1;
      end else begin
         addr_load_q <= soft_reset;
      end
   end

   // matching address changes only on reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_address <= BUS_ADDR_RST[7:0];
      end else if (addr_load_q) begin
         bus_address <= bus_addr_q[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scale_num_q <= SCALE_NUM_RST;
         scale_den_q <= SCALE_DEN_RST;
      end else begin
         if (wr_scale && hit(addr, REG_SCALE_NUM)) begin
            scale_num_q <= wdata;
         end
         if (wr_scale && hit(addr, REG_SCALE_DEN)) begin
            scale_den_q <= wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pressure_q <= ZERO16;
      end else if (wr_pressure) begin
         pressure_q <= wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         press_written_q <= 1'b0;
      end else if (wr_pressure) begin
         press_written_q <= 1'b1;
      end else if (soft_reset) begin
         press_written_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         press_used    <= ZERO16;
         press_applied <= 1'b0;
      end else if (calc_tick) begin
         press_used    <= clamp_press(pressure_q);
         press_applied <= press_written_q && !meter_ctrl_q[CTRL_PCOMP_OFF];
      end
   end

   // engine-facing enables
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         abc_enable     <= 1'b0;
         abc_period     <= ABC_PERIOD_RST;
         iir_dynamic_en <= 1'b0;
         iir_static_en  <= 1'b0;
         press_comp_en  <= 1'b0;
         scale_num      <= SCALE_NUM_RST;
         scale_den      <= SCALE_DEN_RST;
      end else begin
         abc_enable     <= !meter_ctrl_q[CTRL_ABC_OFF] && (abc_period_q != ZERO16);
         abc_period     <= abc_period_q;
         iir_dynamic_en <= !meter_ctrl_q[CTRL_IIR_A] && !meter_ctrl_q[CTRL_IIR_B];
         iir_static_en  <= !(meter_ctrl_q[CTRL_IIR_A] && meter_ctrl_q[CTRL_IIR_B]);
         press_comp_en  <= !meter_ctrl_q[CTRL_PCOMP_OFF];
         scale_num      <= scale_num_q;
         scale_den      <= scale_den_q;
      end
   end

   // read port, data one cycle after strobe, unmapped reads zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_q <= ZERO16;
      end else if (rd) begin
         case (addr)
            REG_CAL_STATUS: rdata_q <= cal_status_q;
            REG_CAL_TARGET: rdata_q <= cal_target_q;
            REG_ABC_PERIOD: rdata_q <= abc_period_q;
            REG_METER_CTRL: rdata_q <= meter_ctrl_q;
            REG_BUS_ADDR:   rdata_q <= bus_addr_q;
            REG_SCALE_NUM:  rdata_q <= scale_num_q;
            REG_SCALE_DEN:  rdata_q <= scale_den_q;
            REG_PRESSURE:   rdata_q <= pressure_q;
            default:        rdata_q <= ZERO16;
         endcase
      end else begin
         rdata_q <= ZERO16;
      end
   end

   assign rdata = rdata_q;

   // echo builder: slave, function, start, count, then crc
   gscr_echo_t  echo_state_q;
   logic [7:0]  echo_bytes [0:5];
   logic [2:0]  echo_idx_q;
   logic        crc_init;
   logic        crc_valid;
   logic [7:0]  crc_byte_in;
   logic [15:0] crc_value;
   logic        echo_accept;

   assign echo_accept = echo_req && (echo_state_q == ECHO_IDLE)
                        && ((echo_func_in == FUNC_READ) || (echo_func_in == FUNC_WRITE));
   assign crc_init    = echo_accept;
   assign crc_valid   = (echo_state_q == ECHO_CRC);
   assign crc_byte_in = echo_bytes[echo_idx_q];

   gscr_crc u_crc (
      .clk        (clk),
      .reset      (reset),
      .init       (crc_init),
      .byte_valid (crc_valid),
      .byte_in    (crc_byte_in),
      .crc        (crc_value)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 6; i++) begin
            echo_bytes[i] <= 8'h00;
         end
         echo_slave <= 8'h00;
         echo_func  <= 8'h00;
         echo_start <= ZERO16;
         echo_count <= ZERO16;
      end else if (echo_accept) begin
         echo_bytes[0] <= bus_address;
         echo_bytes[1] <= echo_func_in;
         echo_bytes[2] <= echo_start_in[15:8];
         echo_bytes[3] <= echo_start_in[7:0];
         echo_bytes[4] <= echo_count_in[15:8];
         echo_bytes[5] <= echo_count_in[7:0];
         echo_slave    <= bus_address;
         echo_func     <= echo_func_in;
         echo_start    <= echo_start_in;
         echo_count    <= echo_count_in;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         echo_state_q <= ECHO_IDLE;
         echo_idx_q   <= 3'h0;
         echo_valid   <= 1'b0;
         echo_crc     <= ZERO16;
      end else begin
         echo_valid <= 1'b0;
         case (echo_state_q)
            ECHO_IDLE: begin
               echo_idx_q <= 3'h0;
               if (echo_accept) begin
                  echo_state_q <= ECHO_CRC;
               end
            end
            ECHO_CRC: begin
               if (echo_idx_q == ECHO_BYTES - 3'h1) begin
                  echo_state_q <= ECHO_DONE;
               end else begin
                  echo_idx_q <= echo_idx_q + 3'h1;
               end
            end
            ECHO_DONE: begin
               echo_crc     <= crc_value;
               echo_valid   <= 1'b1;
               echo_state_q <= ECHO_IDLE;
            end
            default: begin
               echo_state_q <= ECHO_IDLE;
            end
         endcase
      end
   end
endmodule

// file: testbench/gscr_props.sv
// port assertions for the gas sensor register bank
`timescale 1ns/1ns
module gscr_props
   import gscr_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        soft_reset,
   input wire logic [7:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic        calc_tick,
   input wire logic        echo_req,
   input wire logic        echo_valid,
   input wire logic        abc_enable,
   input wire logic [15:0] abc_period,
   input wire logic        iir_dynamic_en,
   input wire logic        iir_static_en,
   input wire logic        press_comp_en,
   input wire logic        press_applied,
   input wire logic [15:0] press_used,
   input wire logic        cal_bg_start,
   input wire logic        cal_target_start,
   input wire logic [7:0]  bus_address
);
   logic mw;
   logic cw;
   logic pw0;
   logic bgw;
   logic tgw;
   assign mw  = wr && addr == REG_METER_CTRL;
   assign cw  = wr && addr == REG_CAL_CMD;
   assign pw0 = wr && addr == REG_ABC_PERIOD && wdata == ZERO16;
   assign bgw = cw && wdata == CMD_CAL_BG;
   assign tgw = cw && wdata == CMD_CAL_TARGET;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_ABC_OFF: assert property (mw && wdata[CTRL_ABC_OFF] |-> ##2 !abc_enable)
      else $error("baseline correction still running");
   AST_PERIOD_ZERO: assert property (pw0 |-> ##2 !abc_enable)
      else $error("zero period left baseline correction on");
   AST_IIR_DYN: assert property (mw && wdata[3:2] == 2'b00 |-> ##2 iir_dynamic_en && iir_static_en)
      else $error("dynamic filter not enabled");
   AST_IIR_NONE: assert property (mw && wdata[3:2] == 2'b11 |-> ##2 !iir_dynamic_en && !iir_static_en)
      else $error("filter left enabled");
   AST_PCOMP_ON: assert property (mw && !wdata[CTRL_PCOMP_OFF] |-> ##2 press_comp_en)
      else $error("pressure compensation not enabled");
   AST_PCOMP_OFF: assert property (mw && wdata[CTRL_PCOMP_OFF] |-> ##2 !press_comp_en)
      else $error("pressure compensation not disabled");
   AST_APPLIED: assert property (calc_tick ##1 !press_comp_en |-> !press_applied)
      else $error("compensation applied while disabled");
   AST_CLAMP: assert property (calc_tick |=>
         $signed(press_used) >= PRESS_MIN && $signed(press_used) <= PRESS_MAX)
      else $error("pressure not clamped");
   AST_PRESS_HOLD: assert property ($changed(press_used) |-> $past(calc_tick))
      else $error("pressure changed without a calculation");
   AST_CAL_BG: assert property (bgw |=> cal_bg_start)
      else $error("background calibration not started");
   AST_CAL_BG_ONLY: assert property (cal_bg_start |-> $past(bgw))
      else $error("background calibration started without command");
   AST_CAL_TGT: assert property (tgw |=> cal_target_start)
      else $error("target calibration not started");
   AST_CAL_TGT_ONLY: assert property (cal_target_start |-> $past(tgw))
      else $error("target calibration started without command");
   AST_ADDR_LATE: assert property ($changed(bus_address) |->
         $past(reset) || $past(soft_reset) || $past(soft_reset, 2) || $past(soft_reset, 3))
      else $error("bus address changed without reset");
   AST_ECHO: assert property (echo_valid |-> $past(echo_req, 8) && !$past(echo_valid))
      else $error("answer header timing wrong");
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside read answer");
   cover property (cal_target_start);
   cover property (echo_valid);
   cover property (calc_tick ##1 press_applied);
endmodule
bind gscr_top gscr_props i_props (.clk, .reset, .soft_reset, .addr, .wdata, .wr, .rd, .rdata, .calc_tick,
   .echo_req, .echo_valid, .abc_enable, .abc_period, .iir_dynamic_en, .iir_static_en, .press_comp_en,
   .press_applied, .press_used, .cal_bg_start, .cal_target_start, .bus_address);

// file: testbench/gscr_host.sv
// modbus host stand-in driving the register port
`timescale 1ns/1ns
module gscr_host
   import gscr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [15:0] rdata,
   output logic      [7:0]  addr,
   output logic      [15:0] wdata,
   output logic             wr,
   output logic             rd
);
   initial begin
      addr = 8'h5a;
      wdata = 16'ha5a5;
      wr = 1'b0;
      rd = 1'b0;
   end
   // idle lines show inverted pattern
   task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   task automatic rmw(input logic [7:0] a, input logic [15:0] keep, input logic [15:0] set);
      logic [15:0] v;
      op(1'b0, a, 16'h0000);
      @(posedge clk);
      v = rdata;
      op(1'b1, a, (v & keep) | set);
   endtask
   task automatic press(input logic [15:0] hpa);
      op(1'b1, REG_PRESSURE, hpa * 16'd10);
   endtask
   task automatic tcal(input logic [15:0] t);
      op(1'b1, REG_CAL_TARGET, t);
      op(1'b1, REG_CAL_CMD, CMD_CAL_TARGET);
   endtask
   task automatic scale(input logic [15:0] n, input logic [15:0] d);
      op(1'b1, REG_SCALE_NUM, n);
      op(1'b1, REG_SCALE_DEN, d);
   endtask
endmodule

// file: testbench/gscr_top_test.sv
// self-checking bench for the gas sensor register bank
`timescale 1ns/1ns
module gscr_top_test;
   import gscr_pkg::*;
   logic clk = 0, reset, soft_reset, calc_tick, echo_req, wr, rd, rd_d = 0;
   logic [7:0] addr, echo_func_in, echo_slave, echo_func, bus_address;
   logic [15:0] wdata, rdata, cal_status_set, echo_start_in, echo_count_in, echo_start, echo_count, echo_crc;
   logic echo_valid, abc_enable, iir_dynamic_en, iir_static_en, press_comp_en, press_applied;
   logic cal_bg_start, cal_target_start;
   logic [15:0] abc_period, press_used, cal_target_value, scale_num, scale_den, n, d, p;
   logic [15:0] rq[$];
   logic [63:0] eq[$];
   logic [55:0] et[10] = '{56'h10_0012_0001_f5a8, 56'h10_000d_0001_3399, 56'h10_0001_0001_3059,
      56'h10_0013_0001_35f9, 56'h10_002e_0001_f968, 56'h10_0014_0002_f508, 56'h03_0012_0001_362d,
      56'h03_0000_0001_338d, 56'h03_0014_0002_368d, 56'h03_000d_0001_f01c};
   logic [19:0] mt[6] = '{20'h0002_7, 20'h000c_9, 20'h0010_e, 20'h0004_b, 20'h0008_b, 20'h0000_f};
   int fails = 0, samples_checked = 0, cyc = 0;
   always #50 clk = ~clk;
   gscr_host i_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   gscr_top i_gscr_top (.clk(clk), .reset(reset), .soft_reset(soft_reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .cal_status_set(cal_status_set), .calc_tick(calc_tick),
      .echo_req(echo_req), .echo_func_in(echo_func_in), .echo_start_in(echo_start_in),
      .echo_count_in(echo_count_in), .echo_valid(echo_valid), .echo_slave(echo_slave),
      .echo_func(echo_func), .echo_start(echo_start), .echo_count(echo_count), .echo_crc(echo_crc),
      .abc_enable(abc_enable), .abc_period(abc_period), .iir_dynamic_en(iir_dynamic_en),
      .iir_static_en(iir_static_en), .press_comp_en(press_comp_en), .press_applied(press_applied),
      .press_used(press_used), .cal_bg_start(cal_bg_start), .cal_target_start(cal_target_start),
      .cal_target_value(cal_target_value), .bus_address(bus_address), .scale_num(scale_num),
      .scale_den(scale_den));
   task automatic end_of_test;
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] g, input logic [63:0] e);
      samples_checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      rq.push_back(e);
      i_host.op(1'b0, a, 16'h0000);
   endtask
   task automatic tick;
      @(posedge clk);
      calc_tick <= 1'b1;
      @(posedge clk);
      calc_tick <= 1'b0;
      #1;
   endtask
   task automatic pulse_soft;
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      wt(4);
   endtask
   task automatic ech(input logic [55:0] e, input logic ok);
      if (ok)
         eq.push_back({BUS_ADDR_RST[7:0], e});
      @(posedge clk);
      echo_req <= 1'b1;
      {echo_func_in, echo_start_in, echo_count_in} <= e[55:16];
      @(posedge clk);
      echo_req <= 1'b0;
      wt(10);
   endtask
   // read answers and answer headers against the oldest note
   always @(posedge clk) begin
      if (rd_d && rq.size() > 0)
         chk("rdata", rdata, rq.pop_front());
      if (echo_valid) begin
         if (eq.size() == 0)
            chk("echo_valid", echo_valid, 1'b0);
         else
            chk("echo", {echo_slave, echo_func, echo_start, echo_count, echo_crc}, eq.pop_front());
      end
      rd_d <= rd;
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      {reset, soft_reset, calc_tick, echo_req} = 4'b1000;
      {cal_status_set, echo_func_in, echo_start_in, echo_count_in} = '0;
      void'($urandom(32'hb7ee));
      wt(4);
      reset <= 1'b0;
      wt(1);
      chk("defaults", {abc_enable, iir_dynamic_en, iir_static_en, press_comp_en, bus_address}, 12'hf68);
      chk("scale", {scale_num, scale_den, abc_period}, 48'h0001_0001_00b4);
      for (int i = 0; i < 10; i++)
         ech(et[i], 1'b1);
      ech(56'h04_0012_0001_0000, 1'b0);
      for (int i = 0; i < 6; i++) begin
         i_host.rmw(REG_METER_CTRL, 16'hffe1, mt[i][19:4]);
         wt(1);
         chk("ctrl", {abc_enable, iir_dynamic_en, iir_static_en, press_comp_en}, mt[i][3:0]);
         rdc(REG_METER_CTRL, mt[i][19:4]);
      end
      i_host.op(1'b1, REG_ABC_PERIOD, 16'h0000);
      wt(1);
      chk("abc_enable", abc_enable, 0);
      i_host.op(1'b1, REG_ABC_PERIOD, 16'h00c8);
      wt(1);
      chk("abc", {abc_enable, abc_period}, 17'h100c8);
      tick();
      chk("press_applied", press_applied, 0);
      i_host.press(16'd997);
      tick();
      chk("press", {press_applied, press_used}, {1'b1, 16'd9970});
      i_host.press(16'd200);
      wt(2);
      chk("press_used", press_used, 16'd9970);
      tick();
      chk("press_used", press_used, 16'd3000);
      i_host.press(16'd1400);
      tick();
      chk("press_used", press_used, 16'd13000);
      p = 16'd300 + 16'($urandom % 1001);
      i_host.press(p);
      tick();
      chk("press_used", press_used, p * 16'd10);
      i_host.rmw(REG_METER_CTRL, 16'hffef, 16'h0010);
      wt(1);
      tick();
      chk("press_applied", press_applied, 0);
      i_host.rmw(REG_METER_CTRL, 16'hffef, 16'h0000);
      wt(1);
      tick();
      chk("press_applied", press_applied, 1);
      i_host.tcal(16'd500);
      #1;
      chk("target", {cal_target_start, cal_target_value}, {1'b1, 16'd500});
      i_host.op(1'b1, REG_CAL_CMD, CMD_CAL_BG);
      #1;
      chk("cal_bg_start", cal_bg_start, 1);
      i_host.op(1'b1, REG_CAL_CMD, 16'h7c07);
      #1;
      chk("cal starts", {cal_bg_start, cal_target_start}, 0);
      rdc(REG_CAL_CMD, 16'h0000);
      @(posedge clk);
      cal_status_set <= 16'h0020;
      @(posedge clk);
      cal_status_set <= 16'h0000;
      rdc(REG_CAL_STATUS, 16'h0020);
      i_host.op(1'b1, REG_CAL_STATUS, 16'h0000);
      rdc(REG_CAL_STATUS, 16'h0000);
      i_host.op(1'b1, REG_BUS_ADDR, 16'h000a);
      wt(3);
      chk("bus_address", bus_address, 8'h68);
      rdc(REG_BUS_ADDR, 16'h000a);
      n = 16'($urandom);
      d = 16'($urandom);
      i_host.scale(n, d);
      pulse_soft();
      chk("bus_address", bus_address, 8'h0a);
      chk("scale", {scale_num, scale_den}, {n, d});
      rdc(REG_SCALE_NUM, n);
      rdc(REG_SCALE_DEN, d);
      tick();
      chk("press_applied", press_applied, 0);
      rdc(8'h7f, 16'h0000);
      wt(3);
      end_of_test();
   end
endmodule
